// file: logic/orc_cfg.svh
// constants for the output range configuration decoder
// Operation
// RQ1 - a write of span code 100 is refused and the old span code stays.
// RQ2 - any change of span code clears the data register to a level set by the clear select and the new code.
// RQ3 - with overrange set, every voltage span is widened by ten percent.
// RQ4 - in dual mode the voltage span comes from the control span code and the current span from the current field.
// RQ5 - in dual mode codes 000 to 011 pick 0-5 V, 0-10 V, +-5 V, +-10 V, 100 is refused, other 1xx disable voltage.
// RQ6 - in dual mode the current field decodes 00 off, 01 4-20 mA, 10 0-20 mA, 11 0-24 mA.
// RQ7 - loop modulation is added only while the 4-20 mA span is selected.
// RQ8 - the host sends an address byte then a data word, 24 bits a frame.
// RQ9 - the host keeps the serial clock at or below 30 MHz; the host model clocks it with a 6 ns period, about 167 MHz.
// RQ10 - the frame is an 8-bit address in the top bits then 16 data bits, msb first.
// RQ11 - in single mode codes 000 to 011 are voltage spans, 100 refused, 101 to 111 are 4-20, 0-20, 0-24 mA.
`ifndef ORC_CFG_SVH
`define ORC_CFG_SVH
`define ORC_FRAME_BITS 24
`define ORC_ADDR_MSB 23
`define ORC_ADDR_LSB 16
`define ORC_ADDR_DATA 8'h01
`define ORC_ADDR_CTRL 8'h55
`define ORC_ADDR_RESET 8'h56
`define ORC_ADDR_CONFIG 8'h57
`define ORC_CTRL_CLRSEL 15
`define ORC_CTRL_OVR 14
`define ORC_CTRL_OUTEN 12
`define ORC_CTRL_SPAN_MSB 2
`define ORC_CFG_ISPAN_MSB 10
`define ORC_CFG_ISPAN_LSB 9
`define ORC_CFG_DUAL 8
`define ORC_SPAN_RESERVED 3'h4
`define ORC_SPAN_RESET 3'h0
`define ORC_ISPAN_RESET 2'h0
`define ORC_DATA_ZERO 16'h0000
`define ORC_DATA_MID 16'h8000
`endif

// file: logic/orc_decoder.sv
// serial command intake and output range decoding
`timescale 1ns/1ns
`include "orc_cfg.svh"
module orc_decoder (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic link_sdi,
  input wire logic link_latch,
  input wire logic clear_level_select,
  output logic [2:0] span_code,
  output logic overrange_enable,
  output logic output_enable,
  output logic dual_output_enable,
  output logic [1:0] current_span_field,
  output orc_pkg::orc_vspan_e voltage_span,
  output orc_pkg::orc_ispan_e current_span,
  output logic voltage_output_enable,
  output logic current_output_enable,
  output logic modulation_enable,
  output logic [15:0] dac_data
);
  // link domain: shift in msb first, capture on latch rise
  logic [23:0] shift; // RQ10
  logic [23:0] frame;
  logic frame_tgl;
  logic lat_s1, lat_s2, lat_prev;
  logic pin_s1, pin_s2;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      shift <= 24'h000000;
    end else begin
      shift <= {shift[22:0], link_sdi}; // RQ8
    end
  end

  // latch is sampled on the system clock; the shift register is stable
  // once the host has stopped clocking, so the word is read after sync
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lat_s1 <= 1'b0;
      lat_s2 <= 1'b0;
      lat_prev <= 1'b0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      lat_s1 <= link_latch;
      lat_s2 <= lat_s1;
      lat_prev <= lat_s2;
      pin_s1 <= clear_level_select;
      pin_s2 <= pin_s1;
    end
  end

  // two-stage capture of the word, aligned with the latch sync
  logic [23:0] frame_s1;
  logic take;
  assign take = lat_s2 & ~lat_prev;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_s1 <= 24'h000000;
      frame <= 24'h000000;
      frame_tgl <= 1'b0;
    end else begin
      frame_s1 <= shift;
      frame <= frame_s1;
      frame_tgl <= take;
    end
  end

  logic [7:0] addr;
  logic [15:0] word;
  assign addr = frame[`ORC_ADDR_MSB:`ORC_ADDR_LSB];
  assign word = frame[15:0];

  logic [2:0] next_span;
  logic span_change;
  always_comb begin
    next_span = span_code;
    if (word[`ORC_CTRL_SPAN_MSB:0] != `ORC_SPAN_RESERVED) begin
      next_span = word[`ORC_CTRL_SPAN_MSB:0]; // RQ1
    end
  end
  assign span_change = frame_tgl && addr == `ORC_ADDR_CTRL &&
                       next_span != span_code;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      span_code <= `ORC_SPAN_RESET;
      overrange_enable <= 1'b0;
      output_enable <= 1'b0;
    end else if (frame_tgl && addr == `ORC_ADDR_RESET && word[0]) begin
      span_code <= `ORC_SPAN_RESET;
      overrange_enable <= 1'b0;
      output_enable <= 1'b0;
    end else if (frame_tgl && addr == `ORC_ADDR_CTRL) begin
      span_code <= next_span; // RQ1
      overrange_enable <= word[`ORC_CTRL_OVR]; // RQ3
      output_enable <= word[`ORC_CTRL_OUTEN];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dual_output_enable <= 1'b0;
      current_span_field <= `ORC_ISPAN_RESET;
    end else if (frame_tgl && addr == `ORC_ADDR_RESET && word[0]) begin
      dual_output_enable <= 1'b0;
      current_span_field <= `ORC_ISPAN_RESET;
    end else if (frame_tgl && addr == `ORC_ADDR_CONFIG) begin
      dual_output_enable <= word[`ORC_CFG_DUAL]; // RQ4
      current_span_field <=
        word[`ORC_CFG_ISPAN_MSB:`ORC_CFG_ISPAN_LSB]; // RQ6
    end
  end

  // clear level: midscale only for bipolar voltage spans with select high;
  // a span change is always a control write, so its own select bit counts
  logic clr_mid;
  assign clr_mid = (word[`ORC_CTRL_CLRSEL] | pin_s2) &&
                   (next_span == 3'h2 || next_span == 3'h3);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dac_data <= `ORC_DATA_ZERO;
    end else if (frame_tgl && addr == `ORC_ADDR_RESET && word[0]) begin
      // soft reset also moves the span back, so the word must clear too
      dac_data <= `ORC_DATA_ZERO; // RQ2
    end else if (span_change) begin
      dac_data <= clr_mid ? `ORC_DATA_MID : `ORC_DATA_ZERO; // RQ2
    end else if (frame_tgl && addr == `ORC_ADDR_DATA) begin
      dac_data <= word;
    end
  end

  // span decode, registered so outputs come from flip-flops
  orc_pkg::orc_vspan_e next_vspan;
  orc_pkg::orc_ispan_e next_ispan;
  always_comb begin
    next_vspan = orc_pkg::ORC_V_OFF;
    next_ispan = orc_pkg::ORC_I_OFF;
    case (span_code)
      3'h0: next_vspan = orc_pkg::ORC_V_0_5; // RQ5 RQ11
      3'h1: next_vspan = orc_pkg::ORC_V_0_10;
      3'h2: next_vspan = orc_pkg::ORC_V_PM5;
      3'h3: next_vspan = orc_pkg::ORC_V_PM10;
      3'h5: next_ispan = orc_pkg::ORC_I_4_20; // RQ11
      3'h6: next_ispan = orc_pkg::ORC_I_0_20;
      3'h7: next_ispan = orc_pkg::ORC_I_0_24;
      default: next_vspan = orc_pkg::ORC_V_OFF;
    endcase
    if (dual_output_enable) begin
      next_ispan = orc_pkg::orc_ispan_e'(current_span_field); // RQ4 RQ6
    end
    if (!output_enable) begin
      next_vspan = orc_pkg::ORC_V_OFF;
      next_ispan = orc_pkg::ORC_I_OFF;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      voltage_span <= orc_pkg::ORC_V_OFF;
      current_span <= orc_pkg::ORC_I_OFF;
      voltage_output_enable <= 1'b0;
      current_output_enable <= 1'b0;
      modulation_enable <= 1'b0;
    end else begin
      voltage_span <= next_vspan;
      current_span <= next_ispan;
      voltage_output_enable <= next_vspan != orc_pkg::ORC_V_OFF;
      current_output_enable <= next_ispan != orc_pkg::ORC_I_OFF;
      // RQ7
      modulation_enable <= next_ispan == orc_pkg::ORC_I_4_20;
    end
  end
endmodule

// file: logic/orc_pkg.sv
// types for the output range configuration decoder
package orc_pkg;
  typedef enum logic [2:0] {
    ORC_V_OFF = 3'b000,
    ORC_V_0_5 = 3'b001,
    ORC_V_0_10 = 3'b010,
    ORC_V_PM5 = 3'b011,
    ORC_V_PM10 = 3'b100
  } orc_vspan_e;
  typedef enum logic [1:0] {
    ORC_I_OFF = 2'b00,
    ORC_I_4_20 = 2'b01,
    ORC_I_0_20 = 2'b10,
    ORC_I_0_24 = 2'b11
  } orc_ispan_e;
endpackage

// file: sim/orc_decoder_sva.sv
// assertions on the range decoder outputs
`timescale 1ns/1ns
module orc_chk (
  input logic sys_clk,
  input logic resetn,
  input logic [2:0] span_code,
  input logic output_enable,
  input logic dual_output_enable,
  input logic [1:0] current_span_field,
  input orc_pkg::orc_vspan_e voltage_span,
  input orc_pkg::orc_ispan_e current_span,
  input logic modulation_enable,
  input logic [15:0] dac_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_new; $changed(span_code); endsequence
  sequence s_sgl; !dual_output_enable ##0 s_new; endsequence
  property p_resv; span_code != 3'h4; endproperty
  a_resv: assert property (p_resv) else $error("resv");
  property p_clr; s_new |-> dac_data inside {16'h0, 16'h8000}; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_v; s_new ##0 !span_code[2] && output_enable |=>
    voltage_span == span_code + 3'h1; endproperty
  a_v: assert property (p_v) else $error("v");
  property p_vdis; dual_output_enable && span_code[2] ##0 s_new |=>
    voltage_span == orc_pkg::ORC_V_OFF; endproperty
  a_vdis: assert property (p_vdis) else $error("vdis");
  property p_id; dual_output_enable && output_enable &&
    $changed(current_span_field) |=> current_span == current_span_field;
  endproperty
  a_id: assert property (p_id) else $error("id");
  property p_is; s_sgl ##0 span_code[2] && output_enable |=>
    current_span == span_code[1:0]; endproperty
  a_is: assert property (p_is) else $error("is");
  property p_io; s_sgl ##0 !span_code[2] |=> current_span == 2'h0;
  endproperty
  a_io: assert property (p_io) else $error("io");
  property p_mod; modulation_enable |-> current_span == orc_pkg::ORC_I_4_20;
  endproperty
  a_mod: assert property (p_mod) else $error("mod");
endmodule
bind orc_decoder orc_chk u_chk (.sys_clk, .resetn, .span_code, .output_enable,
  .dual_output_enable, .current_span_field, .voltage_span, .current_span,
  .modulation_enable, .dac_data);

// file: sim/orc_host.sv
// host model driving the serial command link
`timescale 1ns/1ns
module orc_host (
  output logic link_clk = 1'b0,
  output logic link_sdi = 1'b0,
  output logic link_latch = 1'b0
);
  // clock runs only within a frame, 6 ns period
  task automatic send(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] w;
    w = {a, d};
    for (int i = 23; i >= 0; i--) begin
      link_sdi = w[i];
      #3 link_clk = 1'b1;
      #3 link_clk = 1'b0;
    end
    link_sdi = ~w[0];
    #13 link_latch = 1'b1;
    #21 link_latch = 1'b0;
  endtask
endmodule

// file: sim/tb_orc_decoder.sv
// bench for the output range decoder
`timescale 1ns/1ns
module tb_orc_decoder;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clear_level_select = 1'b0;
  logic link_clk, link_sdi, link_latch, overrange_enable;
  logic output_enable, voltage_output_enable, current_output_enable;
  logic [1:0] current_span_field;
  logic dual_output_enable, modulation_enable;
  logic [2:0] span_code;
  logic [15:0] dac_data;
  orc_pkg::orc_vspan_e voltage_span;
  orc_pkg::orc_ispan_e current_span;
  int fail_count = 0;
  int n_checks = 0;
  always #2 sys_clk = ~sys_clk;
  orc_host host (.link_clk, .link_sdi, .link_latch);
  orc_decoder uut (.sys_clk, .resetn, .link_clk, .link_sdi, .link_latch,
    .clear_level_select, .span_code, .overrange_enable, .output_enable,
    .dual_output_enable, .current_span_field, .voltage_span,
    .current_span, .voltage_output_enable, .current_output_enable,
    .modulation_enable, .dac_data);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    host.send(a, d);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // code 0 equals the reset code, so no clear happens there
  task automatic t_single;
    for (int c = 0; c < 8; c++) begin
      if (c == 4) continue;
      wr(8'h01, 16'h1234);
      wr(8'h55, 16'h1000 | c);
      chk("span", span_code, c);
      chk("data", dac_data, c == 0 ? 16'h1234 : 16'h0);
      chk("vspan", voltage_span, c < 4 ? c + 1 : 0);
      chk("ispan", current_span, c > 4 ? c - 4 : 0);
      chk("mod", modulation_enable, c == 5);
      chk("ven", voltage_output_enable, c < 4);
      chk("ien", current_output_enable, c > 4);
    end
    wr(8'h55, 16'h5004);
    chk("span", span_code, 7);
    chk("ovr", overrange_enable, 1);
  endtask
  task automatic t_clr;
    @(posedge sys_clk) clear_level_select <= 1'b1;
    wr(8'h01, 16'h1234);
    wr(8'h55, 16'h1002);
    chk("data", dac_data, 16'h8000);
    @(posedge sys_clk) clear_level_select <= 1'b0;
    wr(8'h01, 16'h1234);
    wr(8'h55, 16'h9003);
    chk("data", dac_data, 16'h8000);
    wr(8'h55, 16'h9000);
    chk("data", dac_data, 16'h0);
  endtask
  task automatic t_dual;
    for (int f = 0; f < 4; f++) begin
      wr(8'h57, 16'h0100 | (f << 9));
      chk("ispan", current_span, f);
      chk("field", current_span_field, f);
      chk("mod", modulation_enable, f == 1);
    end
    wr(8'h55, 16'h1003);
    chk("vspan", voltage_span, 4);
    chk("ven", voltage_output_enable, 1);
    wr(8'h55, 16'h1006);
    chk("vspan", voltage_span, 0);
    chk("ispan", current_span, 3);
    chk("ven", voltage_output_enable, 0);
    chk("ien", current_output_enable, 1);
  endtask
  // unknown address, outputs switched off, then the soft reset command
  task automatic t_reset;
    wr(8'h01, 16'h4321);
    wr(8'h33, 16'hffff);
    chk("data", dac_data, 16'h4321);
    chk("span", span_code, 6);
    wr(8'h55, 16'h0001);
    chk("data", dac_data, 16'h0);
    chk("oe", output_enable, 0);
    chk("vspan", voltage_span, 0);
    chk("ispan", current_span, 0);
    chk("ven", voltage_output_enable, 0);
    chk("ien", current_output_enable, 0);
    chk("mod", modulation_enable, 0);
    wr(8'h01, 16'h4321);
    wr(8'h56, 16'h0001);
    chk("span", span_code, 0);
    chk("dual", dual_output_enable, 0);
    chk("field", current_span_field, 0);
    chk("data", dac_data, 16'h0);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("span", span_code, 0);
    t_single;
    t_clr;
    t_dual;
    t_reset;
    end_of_test;
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
endmodule
